// >>> include/timer_pkg.sv
/*
 * Constants for the dual timer/counter: register offsets, field positions,
 * reset values, mode encoding and the peripheral-cycle divide ratio.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package timer_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_LOW_T0 = 8'h08;
    localparam logic [7:0] ADDR_HIGH_T0 = 8'h0C;
    localparam logic [7:0] ADDR_LOW_T1 = 8'h10;
    localparam logic [7:0] ADDR_HIGH_T1 = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // Control register bit positions
    localparam int CTL_OVF_T1 = 7;
    localparam int CTL_RUN_T1 = 6;
    localparam int CTL_OVF_T0 = 5;
    localparam int CTL_RUN_T0 = 4;

    // Mode register bit positions
    localparam int MODE_GATE_T1 = 7;
    localparam int MODE_CSEL_T1 = 6;
    localparam int MODE_SEL_HI_T1 = 5;
    localparam int MODE_SEL_LO_T1 = 4;
    localparam int MODE_GATE_T0 = 3;
    localparam int MODE_CSEL_T0 = 2;
    localparam int MODE_SEL_HI_T0 = 1;
    localparam int MODE_SEL_LO_T0 = 0;

    // Interrupt enable register bit positions
    localparam int IEN_GLOBAL = 7;
    localparam int IEN_T1 = 3;
    localparam int IEN_T0 = 1;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // One peripheral cycle in core clocks, and the divider's last count
    localparam int PER_CYCLE_CLKS = 6;
    localparam logic [2:0] DIV_LAST = 3'(PER_CYCLE_CLKS - 1);

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Operating modes, Gray order along 0-1-3-2 is not needed; codes as documented
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_type;

endpackage : timer_pkg

// >>> src/dual_timer.sv
/*
 * Two 8051-style timer/counters behind an AXI4-Lite register slave.
 * Assumes core_clk is the peripheral clock, count and gate pins are
 * synchronous to it, and the core pulses vector_ack_* when it vectors.
 */
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Gate clear: run bit lets the selected input advance the low count.
// - Gate and run both set: external interrupt pin decides whether counting proceeds.
// - Gated timer counts only while its pin is high and run is set; with timer 0 in mode 3, timer 1 counts without run_t1.
// - Timer 0 uses low mode nibble, control bits 4,5; timer 1 the high mode nibble, control bits 6,7.
// - Timer operation advances once per peripheral cycle of six clocks.
// - Counter samples pin each peripheral cycle; high then low sample increments.
// - Rollover from all ones to zero sets that timer's overflow flag; with timer 0 in mode 3, timer 1 rollover sets no flag.
// - Mode 0: five-bit prescaler in low register carries into high register.
// - Mode 0: upper three low-register bits do not count.
// - Mode 1: low and high registers cascade into sixteen bits.
// - Mode 2: low overflow sets flag and reloads low from unchanged high.
// - Mode 2: high register writes accepted anytime, used at next reload.
// - Mode 3: timer 0 low is an 8-bit timer with timer 0 controls.
// - Mode 3: timer 0 high counts cycles, runs on run_t1, sets overflow_flag_t1.
// - Timer 1 in mode 3 halts and holds its count.
// - Timer 1 overflow is offered as serial baud-rate source.
// - Vectoring to a timer's interrupt clears its overflow flag.
// - Interrupt request needs timer enable and global enable both set.
// - Counter-select picks divided clock or external pin per timer.
module dual_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic count_pin_t0,
    input wire logic count_pin_t1,
    input wire logic ext_irq_pin_0,
    input wire logic ext_irq_pin_1,
    input wire logic vector_ack_t0,
    input wire logic vector_ack_t1,
    output logic irq_t0,
    output logic irq_t1,
    output logic baud_tick_t1
);
    import timer_pkg::*;

    typedef struct packed {
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [7:0] w_data;
        logic w_strb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] div;
        logic [7:0] timer_control_reg;
        logic [7:0] timer_mode_reg;
        logic [7:0] count_low_t0;
        logic [7:0] count_high_t0;
        logic [7:0] count_low_t1;
        logic [7:0] count_high_t1;
        logic [7:0] irq_enable_reg;
        logic samp_t0;
        logic samp_t1;
        logic irq_t0;
        logic irq_t1;
        logic baud_tick;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic rst_meta_q;
    logic rst_sync_q;

    // Combinational helpers, also watched by the checks below
    logic tick;
    logic wr_fire;
    logic en_t0;
    logic en_t1;
    logic inc_t0;
    logic inc_t1;
    logic inc_high_t0;
    logic ovf_t0;
    logic ovf_t1;
    logic ovf_high_t0;
    logic split_t0;
    logic [16:0] step_t0;
    logic [16:0] step_t1;
    timer_mode_type mode_t0;
    timer_mode_type mode_t1;

    // One count step: returns {overflow, high, low}
    function automatic logic [16:0] count_step(input timer_mode_type m, input logic [7:0] lo,
                                              input logic [7:0] hi, input logic inc);
        logic [8:0] sum_lo;
        logic [8:0] sum_hi;
        logic [5:0] sum_pre;
        logic ovf;
        logic [7:0] nlo;
        logic [7:0] nhi;
        sum_lo = {1'b0, lo} + 9'h001;
        sum_hi = {1'b0, hi} + 9'h001;
        sum_pre = {1'b0, lo[4:0]} + 6'h01;
        ovf = 1'b0;
        nlo = lo;
        nhi = hi;
        if (inc) begin
            case (m)
                MODE_13BIT: begin
                    nlo = {lo[7:5], sum_pre[4:0]};
                    if (sum_pre[5]) begin
                        nhi = sum_hi[7:0];
                        ovf = sum_hi[8];
                    end
                end
                MODE_16BIT: begin
                    nlo = sum_lo[7:0];
                    if (sum_lo[8]) begin
                        nhi = sum_hi[7:0];
                        ovf = sum_hi[8];
                    end
                end
                MODE_RELOAD: begin
                    nlo = sum_lo[8] ? hi : sum_lo[7:0];
                    ovf = sum_lo[8];
                end
                default: begin
                    nlo = sum_lo[7:0];
                    ovf = sum_lo[8];
                end
            endcase
        end
        return {ovf, nhi, nlo};
    endfunction : count_step

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Peripheral-cycle tick and per-timer count enables
    always_comb begin
        tick = (s_q.div == DIV_LAST);
        mode_t0 = timer_mode_type'({s_q.timer_mode_reg[MODE_SEL_HI_T0],
                                    s_q.timer_mode_reg[MODE_SEL_LO_T0]});
        mode_t1 = timer_mode_type'({s_q.timer_mode_reg[MODE_SEL_HI_T1],
                                    s_q.timer_mode_reg[MODE_SEL_LO_T1]});
        split_t0 = (mode_t0 == MODE_SPLIT);
        // Run bit alone when gate clear; pin high also needed when gate set
        en_t0 = s_q.timer_control_reg[CTL_RUN_T0] &
                (~s_q.timer_mode_reg[MODE_GATE_T0] | ext_irq_pin_0);
        // With timer 0 split, run_t1 belongs to the high half; mode 3 stops timer 1
        en_t1 = (split_t0 | s_q.timer_control_reg[CTL_RUN_T1]) &
                (~s_q.timer_mode_reg[MODE_GATE_T1] | ext_irq_pin_1) &
                (mode_t1 != MODE_SPLIT);
        // Timer clock or falling edge between two pin samples
        inc_t0 = en_t0 & tick & (s_q.timer_mode_reg[MODE_CSEL_T0] ?
                 (s_q.samp_t0 & ~count_pin_t0) : 1'b1);
        inc_t1 = en_t1 & tick & (s_q.timer_mode_reg[MODE_CSEL_T1] ?
                 (s_q.samp_t1 & ~count_pin_t1) : 1'b1);
        inc_high_t0 = split_t0 & tick & s_q.timer_control_reg[CTL_RUN_T1];
        step_t0 = count_step(mode_t0, s_q.count_low_t0, s_q.count_high_t0, inc_t0);
        step_t1 = count_step(mode_t1, s_q.count_low_t1, s_q.count_high_t1, inc_t1);
        ovf_t0 = step_t0[16];
        ovf_t1 = step_t1[16];
        ovf_high_t0 = inc_high_t0 & (s_q.count_high_t0 == 8'hFF);
        wr_fire = s_q.aw_hold & s_q.w_hold & ~s_q.bvalid;
    end

    // Next state: bus slave, counting, software writes, flags
    always_comb begin
        s_d = s_q;
        s_d.div = tick ? 3'h0 : s_q.div + 3'h1;
        // Pin samples taken once per peripheral cycle
        if (tick) begin
            s_d.samp_t0 = count_pin_t0;
            s_d.samp_t1 = count_pin_t1;
        end
        // Write address and data may arrive in either order
        if (s_axi_awvalid & s_q.awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_q.wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_data = s_axi_wdata[7:0];
            s_d.w_strb0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Counting; low of timer 0 split keeps using timer 0 controls
        s_d.count_low_t0 = step_t0[7:0];
        s_d.count_high_t0 = split_t0 ? (inc_high_t0 ? s_q.count_high_t0 + 8'h01
                            : s_q.count_high_t0) : step_t0[15:8];
        s_d.count_low_t1 = step_t1[7:0];
        s_d.count_high_t1 = step_t1[15:8];
        // Register write; software value overrides a same-cycle count
        if (wr_fire) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (s_q.aw_addr == ADDR_CONTROL) begin
                if (s_q.w_strb0) begin
                    s_d.timer_control_reg = {s_q.w_data[7:4], 4'h0};
                end
            end else if (s_q.aw_addr == ADDR_MODE) begin
                if (s_q.w_strb0) begin
                    s_d.timer_mode_reg = s_q.w_data;
                end
            end else if (s_q.aw_addr == ADDR_LOW_T0) begin
                if (s_q.w_strb0) begin
                    s_d.count_low_t0 = s_q.w_data;
                end
            end else if (s_q.aw_addr == ADDR_HIGH_T0) begin
                if (s_q.w_strb0) begin
                    s_d.count_high_t0 = s_q.w_data;
                end
            end else if (s_q.aw_addr == ADDR_LOW_T1) begin
                if (s_q.w_strb0) begin
                    s_d.count_low_t1 = s_q.w_data;
                end
            end else if (s_q.aw_addr == ADDR_HIGH_T1) begin
                if (s_q.w_strb0) begin
                    s_d.count_high_t1 = s_q.w_data;
                end
            end else if (s_q.aw_addr == ADDR_IRQ_ENABLE) begin
                if (s_q.w_strb0) begin
                    s_d.irq_enable_reg = s_q.w_data;
                end
            end else begin
                s_d.bresp = RESP_DECERR;
            end
        end
        // Vectoring clears flags; a same-cycle overflow still sets them
        if (vector_ack_t0) begin
            s_d.timer_control_reg[CTL_OVF_T0] = 1'b0;
        end
        if (vector_ack_t1) begin
            s_d.timer_control_reg[CTL_OVF_T1] = 1'b0;
        end
        if (ovf_t0) begin
            s_d.timer_control_reg[CTL_OVF_T0] = 1'b1;
        end
        if (ovf_high_t0 | (ovf_t1 & ~split_t0)) begin
            s_d.timer_control_reg[CTL_OVF_T1] = 1'b1;
        end
        s_d.baud_tick = ovf_t1;
        // Read channel
        if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid & s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = RESET_WORD;
            if (s_axi_araddr == ADDR_CONTROL) begin
                s_d.rdata[7:0] = s_q.timer_control_reg;
            end else if (s_axi_araddr == ADDR_MODE) begin
                s_d.rdata[7:0] = s_q.timer_mode_reg;
            end else if (s_axi_araddr == ADDR_LOW_T0) begin
                s_d.rdata[7:0] = s_q.count_low_t0;
            end else if (s_axi_araddr == ADDR_HIGH_T0) begin
                s_d.rdata[7:0] = s_q.count_high_t0;
            end else if (s_axi_araddr == ADDR_LOW_T1) begin
                s_d.rdata[7:0] = s_q.count_low_t1;
            end else if (s_axi_araddr == ADDR_HIGH_T1) begin
                s_d.rdata[7:0] = s_q.count_high_t1;
            end else if (s_axi_araddr == ADDR_IRQ_ENABLE) begin
                s_d.rdata[7:0] = s_q.irq_enable_reg;
            end else begin
                s_d.rresp = RESP_DECERR;
            end
        end
        // Ready only while the channel has room
        s_d.awready = ~s_d.aw_hold & ~s_d.bvalid;
        s_d.wready = ~s_d.w_hold & ~s_d.bvalid;
        s_d.arready = ~s_d.rvalid;
        // Requests pass only with own and global enables set
        s_d.irq_t0 = s_d.timer_control_reg[CTL_OVF_T0] & s_d.irq_enable_reg[IEN_T0] &
                     s_d.irq_enable_reg[IEN_GLOBAL];
        s_d.irq_t1 = s_d.timer_control_reg[CTL_OVF_T1] & s_d.irq_enable_reg[IEN_T1] &
                     s_d.irq_enable_reg[IEN_GLOBAL];
    end

    // State register; everything cleared at reset
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign irq_t0 = s_q.irq_t0;
    assign irq_t1 = s_q.irq_t1;
    assign baud_tick_t1 = s_q.baud_tick;

    // Checks on the counting, flag and interrupt logic
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_q);

    property p_timer_advance;
        (tick && mode_t0 == MODE_16BIT && en_t0 && !s_q.timer_mode_reg[MODE_CSEL_T0]
         && s_q.count_low_t0 != 8'hFF && !wr_fire)
        |=> s_q.count_low_t0 == $past(s_q.count_low_t0) + 8'h01;
    endproperty
    a_timer_advance: assert property (p_timer_advance) else $error("low count missed tick");

    property p_gate_blocks;
        (s_q.timer_mode_reg[MODE_GATE_T0] && !ext_irq_pin_0 && !split_t0 && !wr_fire)
        |=> $stable(s_q.count_low_t0) && $stable(s_q.count_high_t0);
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer counted");

    property p_overflow_flag;
        (inc_t0 && mode_t0 == MODE_16BIT && s_q.count_low_t0 == 8'hFF
         && s_q.count_high_t0 == 8'hFF)
        |=> s_q.timer_control_reg[CTL_OVF_T0] ##1 irq_t0 == (s_q.irq_enable_reg[IEN_T0]
            && s_q.irq_enable_reg[IEN_GLOBAL] && s_q.timer_control_reg[CTL_OVF_T0]);
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set");

    property p_reload;
        (inc_t1 && mode_t1 == MODE_RELOAD && s_q.count_low_t1 == 8'hFF && !wr_fire)
        |=> s_q.count_low_t1 == $past(s_q.count_high_t1) && $stable(s_q.count_high_t1)
            && baud_tick_t1;
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");

    property p_halt_t1;
        (mode_t1 == MODE_SPLIT && !wr_fire)
        |=> $stable(s_q.count_low_t1) && $stable(s_q.count_high_t1);
    endproperty
    a_halt_t1: assert property (p_halt_t1) else $error("timer 1 moved in mode 3");

    property p_split_high;
        (inc_high_t0 && s_q.count_high_t0 == 8'hFF && !wr_fire)
        |=> s_q.count_high_t0 == 8'h00 && s_q.timer_control_reg[CTL_OVF_T1];
    endproperty
    a_split_high: assert property (p_split_high) else $error("split high overflow lost");

    property p_irq_gate;
        irq_t1 |-> s_q.irq_enable_reg[IEN_GLOBAL] && s_q.irq_enable_reg[IEN_T1];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without enables");

    property p_vector_clear;
        (vector_ack_t0 && !ovf_t0) |=> !s_q.timer_control_reg[CTL_OVF_T0] ##1 !irq_t0;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("flag not cleared");

    // A pin that stays high between two samples must not count
    property p_counter_edge;
        (tick && s_q.timer_mode_reg[MODE_CSEL_T1] && s_q.samp_t1 && count_pin_t1)
        |-> !inc_t1;
    endproperty
    a_counter_edge: assert property (p_counter_edge) else $error("count without edge");

    property p_counter_no_edge;
        (tick && s_q.timer_mode_reg[MODE_CSEL_T1]) |-> (inc_t1 == (en_t1 && s_q.samp_t1
            && !count_pin_t1));
    endproperty
    a_counter_no_edge: assert property (p_counter_no_edge) else $error("bad edge count");

    property p_prescale_carry;
        (inc_t0 && mode_t0 == MODE_13BIT && s_q.count_low_t0[4:0] == 5'h1F && !wr_fire)
        |=> s_q.count_low_t0[4:0] == 5'h00 && s_q.count_high_t0 == $past(s_q.count_high_t0)
            + 8'h01 && s_q.count_low_t0[7:5] == $past(s_q.count_low_t0[7:5]);
    endproperty
    a_prescale_carry: assert property (p_prescale_carry) else $error("prescaler carry");

    c_overflow_t0: cover property (ovf_t0);
    c_reload_t1: cover property (ovf_t1 && mode_t1 == MODE_RELOAD);
    c_split_high: cover property (ovf_high_t0);
    c_counter_edge: cover property (inc_t1 && s_q.timer_mode_reg[MODE_CSEL_T1]);

endmodule : dual_timer

`default_nettype wire

// >>> bench/pin_source.sv
/*
 * Far-side model of the count and gate pins of both timers.
 * Assumes the bench calls its tasks and core_clk is the design clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_source (
    input wire logic core_clk,
    output logic count_pin_t0,
    output logic count_pin_t1,
    output logic ext_irq_pin_0,
    output logic ext_irq_pin_1
);
    // Count pins idle low, gates open
    initial begin
        count_pin_t0 = 1'b0;
        count_pin_t1 = 1'b0;
        ext_irq_pin_0 = 1'b1;
        ext_irq_pin_1 = 1'b1;
    end

    // Drive one count pin after a clock edge
    task automatic set_pin(input logic t, input logic v);
        @(posedge core_clk);
        if (t) count_pin_t1 <= v;
        else count_pin_t0 <= v;
    endtask : set_pin

    // Each level holds two peripheral cycles so a sample always sees it
    task automatic pulses(input logic t, input int n);
        for (int i = 0; i < n; i++) begin
            set_pin(t, 1'b1);
            repeat (12) @(posedge core_clk);
            set_pin(t, 1'b0);
            repeat (12) @(posedge core_clk);
        end
    endtask : pulses

    // Open or close one gate pin
    task automatic gate(input logic t, input logic v);
        @(posedge core_clk);
        if (t) ext_irq_pin_1 <= v;
        else ext_irq_pin_0 <= v;
    endtask : gate
endmodule : pin_source
`default_nettype wire

// >>> bench/testbench.sv
/*
 * Self-checking bench for the dual timer: table of counter cases, then
 * timer, gating, split mode, interrupt, unmapped and reset tests.
 * Assumes the AXI4-Lite slave and pin model of this folder.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import timer_pkg::*;
    typedef struct packed {
        logic t;
        logic [7:0] mode, low0, high0;
        int n;
        logic [7:0] low, high, ctl;
    } row_type;
    // Counter-mode cases: timer, mode, preload, edges, expected low, high, control
    row_type rows [7] = '{
        '{1'b0, 8'h05, 8'hFE, 8'h00, 3, 8'h01, 8'h01, 8'h10},
        '{1'b0, 8'h05, 8'hFF, 8'hFF, 1, 8'h00, 8'h00, 8'h30},
        '{1'b0, 8'h04, 8'hFE, 8'h00, 3, 8'hE1, 8'h01, 8'h10},
        '{1'b0, 8'h04, 8'h1F, 8'hFF, 1, 8'h00, 8'h00, 8'h30},
        '{1'b0, 8'h06, 8'hFE, 8'h80, 3, 8'h81, 8'h80, 8'h30},
        '{1'b1, 8'h50, 8'h10, 8'h20, 2, 8'h12, 8'h20, 8'h40},
        '{1'b1, 8'h60, 8'hFF, 8'h40, 2, 8'h41, 8'h40, 8'hC0}
    };
    logic core_clk = 1'b0, rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq_t0, irq_t1, baud_tick_t1;
    logic [1:0] bresp, rresp, resp;
    logic ack_t0 = 1'b0, ack_t1 = 1'b0, pin_c0, pin_c1, pin_g0, pin_g1;
    logic [7:0] d;
    int errors = 0, samples_checked = 0, baud_count = 0;

    always #12.5 core_clk = ~core_clk;
    // Count baud-rate pulses
    always @(posedge core_clk) if (baud_tick_t1 === 1'b1) baud_count <= baud_count + 1;

    pin_source u_pins (.core_clk(core_clk), .count_pin_t0(pin_c0), .count_pin_t1(pin_c1),
        .ext_irq_pin_0(pin_g0), .ext_irq_pin_1(pin_g1));
    dual_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .count_pin_t0(pin_c0), .count_pin_t1(pin_c1),
        .ext_irq_pin_0(pin_g0), .ext_irq_pin_1(pin_g1), .vector_ack_t0(ack_t0),
        .vector_ack_t1(ack_t1), .irq_t0(irq_t0), .irq_t1(irq_t1),
        .baud_tick_t1(baud_tick_t1));

    // Print counts and verdict, then stop
    task automatic complete_run;
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // AXI write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 200 && !done; i++) begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            errors++;
            complete_run();
        end
    endtask : wr

    // AXI read: data and response taken at the handshake edge
    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 200 && !done; i++) begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata[7:0];
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            errors++;
            complete_run();
        end
    endtask : rd

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        // Counter-mode table
        foreach (rows[k]) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_MODE, rows[k].mode);
            wr(rows[k].t ? ADDR_LOW_T1 : ADDR_LOW_T0, rows[k].low0);
            wr(rows[k].t ? ADDR_HIGH_T1 : ADDR_HIGH_T0, rows[k].high0);
            wr(ADDR_CONTROL, rows[k].t ? 8'h40 : 8'h10);
            u_pins.pulses(rows[k].t, rows[k].n);
            rd(rows[k].t ? ADDR_LOW_T1 : ADDR_LOW_T0);
            check(d, rows[k].low);
            rd(rows[k].t ? ADDR_HIGH_T1 : ADDR_HIGH_T0);
            check(d, rows[k].high);
            rd(ADDR_CONTROL);
            check(d, rows[k].ctl);
            wr(ADDR_CONTROL, 8'h00);
        end
        check(baud_count[7:0], 8'h01);
        // Timer operation: run stands 120 clocks (4 of them in the two writes), 20 cycles
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_LOW_T0, 8'h00);
        wr(ADDR_CONTROL, 8'h10);
        repeat (116) @(posedge core_clk);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_LOW_T0);
        check(d, 8'h14);
        // Gated counter: closed gate blocks edges, open gate passes them
        wr(ADDR_MODE, 8'h0D);
        wr(ADDR_LOW_T0, 8'h00);
        u_pins.gate(1'b0, 1'b0);
        wr(ADDR_CONTROL, 8'h10);
        u_pins.pulses(1'b0, 2);
        rd(ADDR_LOW_T0);
        check(d, 8'h00);
        u_pins.gate(1'b0, 1'b1);
        u_pins.pulses(1'b0, 3);
        rd(ADDR_LOW_T0);
        check(d, 8'h03);
        wr(ADDR_CONTROL, 8'h00);
        // Split mode: high half runs on run_t1 and sets its flag; timer 1 held
        wr(ADDR_MODE, 8'h33);
        wr(ADDR_LOW_T0, 8'hAA);
        wr(ADDR_HIGH_T0, 8'hFF);
        wr(ADDR_LOW_T1, 8'h55);
        wr(ADDR_CONTROL, 8'h40);
        repeat (24) @(posedge core_clk);
        rd(ADDR_CONTROL);
        check(d, 8'hC0);
        rd(ADDR_LOW_T0);
        check(d, 8'hAA);
        rd(ADDR_LOW_T1);
        check(d, 8'h55);
        // Interrupt needs both enables; vectoring clears the flag
        wr(ADDR_IRQ_ENABLE, 8'h08);
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_t1}, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h88);
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_t1}, 8'h01);
        ack_t1 <= 1'b1;
        @(posedge core_clk);
        ack_t1 <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_t1}, 8'h00);
        rd(ADDR_CONTROL);
        check(d, 8'h40);
        // Timer 0 request: flag set by software, both enables, then vectoring
        wr(ADDR_CONTROL, 8'h60);
        wr(ADDR_IRQ_ENABLE, 8'h82);
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_t0}, 8'h01);
        ack_t0 <= 1'b1;
        @(posedge core_clk);
        ack_t0 <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_t0}, 8'h00);
        // Unmapped offset is refused
        wr(8'h1C, 8'h5A);
        check({6'h0, resp}, {6'h0, RESP_DECERR});
        rd(8'h1C);
        check({6'h0, resp}, {6'h0, RESP_DECERR});
        // Second reset in mid-run clears every register
        rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        for (int a = 0; a < 7; a++) begin
            rd(8'(a * 4));
            check(d, RESET_BYTE);
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
